//--- design/gsmc_filt_if.sv
// Carrier between the sequencer and the measurement filter
interface gsmc_filt_if;
   logic sample_stb;
   logic [15:0] sample;
   logic [15:0] zero_pt;
   logic [3:0] setting;
   logic done;
   logic [15:0] raw_out;
   logic [15:0] filt_out;
   modport seq (output sample_stb, sample, zero_pt, setting,
                input done, raw_out, filt_out);
   modport filt (input sample_stb, sample, zero_pt, setting,
                 output done, raw_out, filt_out);
endinterface : gsmc_filt_if

//--- design/gsmc_filter.sv
// Zero correction and selectable low-pass filter of each measurement
module gsmc_filter (
   input wire logic clock,
   input wire logic reset_n,
   gsmc_filt_if.filt fi
);
   import gsmc_pkg::*;

   logic [15:0] raw_r, raw_nxt;
   logic [15:0] filt_r, filt_nxt;
   logic done_r, done_nxt;
   logic primed_r, primed_nxt;
   logic signed [17:0] corr;
   logic signed [17:0] diff;

   ////////////////////////////////////////////////////////////////////////
   // Next values; a larger setting is a longer shift, less noise, slower
   always_comb begin
      raw_nxt = raw_r;
      filt_nxt = filt_r;
      primed_nxt = primed_r;
      done_nxt = 1'b0;
      corr = $signed({2'b00, fi.sample}) - $signed({2'b00, fi.zero_pt});
      if (corr < 0) begin
         corr = '0;
      end
      diff = corr - $signed({2'b00, filt_r});
      if (fi.sample_stb) begin
         raw_nxt = corr[15:0];
         done_nxt = 1'b1;
         primed_nxt = 1'b1;
         // First sample seeds the filter so it does not ramp from zero
         if (!primed_r) begin
            filt_nxt = corr[15:0];
         end else begin
            filt_nxt = 16'(filt_r + 16'(diff >>> fi.setting));
         end
      end
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         raw_r <= 16'h0000;
         filt_r <= 16'h0000;
         done_r <= 1'b0;
         primed_r <= 1'b0;
      end else begin
         raw_r <= raw_nxt;
         filt_r <= filt_nxt;
         done_r <= done_nxt;
         primed_r <= primed_nxt;
      end
   end

   assign fi.raw_out = raw_r;
   assign fi.filt_out = filt_r;
   assign fi.done = done_r;
endmodule : gsmc_filter

//--- design/gsmc_pkg.sv
// Constants and types shared by the measure cycle sequencer and its filter
package gsmc_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   // Power-on to first valid data-ready, least time
   localparam int T_FIRST_MS = 800;
   localparam int FIRST_CYC = (T_FIRST_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   // Data-ready low after power-on, longest time
   localparam int T_LOW_MAX_MS = 100;
   localparam int LOW_MAX_CYC = (T_LOW_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
   // Data-ready high width, 16.5 ms held in tenths of a millisecond
   localparam int T_PULSE_MS_X10 = 165;
   localparam int PULSE_CYC = (T_PULSE_MS_X10 * (NS_PER_MS / 10))
                              / CLK_PERIOD_NS;
   // Measurement period, 0.5 s held in milliseconds
   localparam int T_PERIOD_MS = 500;
   localparam int PERIOD_CYC = (T_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
   // UART bit time at the fixed rate
   localparam int UART_BAUD = 9600;
   localparam int BAUD_CYC = (1000000000 / CLK_PERIOD_NS) / UART_BAUD;
   // Zero-point targets and range, in ppm
   localparam int DATA_W = 16;
   localparam logic [15:0] FRESH_REF_RST = 16'h0190;
   localparam logic [15:0] KNOWN_REF_RST = 16'h0000;
   localparam logic [15:0] N2_TARGET = 16'h0000;
   localparam logic [15:0] FULL_SCALE_DEF = 16'h07D0;
   // Filter setting width and reset value
   localparam int FILT_W = 4;
   localparam logic [3:0] FILT_RST = 4'h4;
   // Cycles that the select pin needs through its synchroniser
   localparam logic [1:0] SEL_CAPTURE_AT = 2'h3;

   typedef enum logic [2:0] {
      GSMC_RD_FILT,
      GSMC_RD_RAW,
      GSMC_WR_KNOWN,
      GSMC_WR_FRESH,
      GSMC_WR_FILT,
      GSMC_ZERO_KNOWN,
      GSMC_ZERO_N2,
      GSMC_ZERO_FRESH
   } gsmc_cmd_t;
endpackage : gsmc_pkg

//--- design/gsmc_top.sv
// Gas sensor measurement cycle, data-ready pacing and host gating
// Function
// - Sample select pin once after reset: low means I2C, else UART.
// - Measurements start by themselves after reset with current settings.
// - Host requests taken only after the first data-ready pulse ends.
// - First valid data-ready comes no sooner than 800 ms after reset.
// - Data-ready is low within 100 ms of reset.
// - Each data-ready pulse stays high 16.5 ms.
// - Host requests ignored while data-ready is high; host uses low time.
// - Measure every 0.5 s, refresh result, pulse data-ready each period.
// - UART mode bit rate fixed at 9600 baud.
// - First data-ready delay grows with the filter setting.
// - Filtered output uses a selectable low-pass setting.
// - Raw unfiltered result is also readable.
// - Only the latest zero point is kept, whatever method set it.
// - Nitrogen zero assumes zero ppm.
// - Fresh-air zero uses reference defaulting to 400 ppm, writable.
module gsmc_top #(
   parameter int FIRST_CYCLES = gsmc_pkg::FIRST_CYC,
   parameter int PERIOD_CYCLES = gsmc_pkg::PERIOD_CYC,
   parameter int PULSE_CYCLES = gsmc_pkg::PULSE_CYC,
   parameter int BAUD_CYCLES = gsmc_pkg::BAUD_CYC,
   parameter logic [15:0] FULL_SCALE = gsmc_pkg::FULL_SCALE_DEF
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic iface_sel_pin,
   input wire logic [15:0] sensor_sample,
   input wire logic host_req,
   input wire gsmc_pkg::gsmc_cmd_t host_cmd,
   input wire logic [15:0] host_wdata,
   output logic data_ready,
   output logic i2c_mode,
   output logic host_ack,
   output logic host_ignored,
   output logic [15:0] host_rdata,
   output logic baud_tick,
   output logic [15:0] zero_point,
   output logic [3:0] filter_setting
);
   import gsmc_pkg::*;

   typedef enum {RDY_BOOT, RDY_LOW, RDY_HIGH} gsmc_rdy_t;

   gsmc_filt_if fi ();
   gsmc_filter u_filter (
      .clock(clock),
      .reset_n(reset_n),
      .fi(fi)
   );

   gsmc_rdy_t st_r, st_nxt;
   logic sel_s1_r, sel_s2_r;
   logic [1:0] sel_cnt_r, sel_cnt_nxt;
   logic i2c_r, i2c_nxt;
   logic [31:0] per_cnt_r, per_cnt_nxt;
   logic [31:0] up_cnt_r, up_cnt_nxt;
   logic [31:0] pulse_cnt_r, pulse_cnt_nxt;
   logic [31:0] baud_cnt_r, baud_cnt_nxt;
   logic baud_r, baud_nxt;
   logic [3:0] meas_n_r, meas_n_nxt;
   logic [15:0] last_sample_r, last_sample_nxt;
   logic [15:0] zero_r, zero_nxt;
   logic [15:0] known_r, known_nxt;
   logic [15:0] fresh_r, fresh_nxt;
   logic [3:0] filt_set_r, filt_set_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic ack_r, ack_nxt;
   logic ign_r, ign_nxt;
   logic meas_stb;
   logic accept;

   ////////////////////////////////////////////////////////////////////////
   // Select pin synchroniser; first stage feeds only the second
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
      end else begin
         sel_s1_r <= iface_sel_pin;
         sel_s2_r <= sel_s1_r;
      end
   end

   // Port mode caught once, after the synchroniser has filled
   always_comb begin
      sel_cnt_nxt = sel_cnt_r;
      i2c_nxt = i2c_r;
      if (sel_cnt_r != SEL_CAPTURE_AT) begin
         sel_cnt_nxt = 2'(sel_cnt_r + 2'h1);
         if (sel_cnt_r == 2'(SEL_CAPTURE_AT - 2'h1)) begin
            i2c_nxt = !sel_s2_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Free-running measurement period and power-on elapsed time
   always_comb begin
      meas_stb = 1'b0;
      per_cnt_nxt = 32'(per_cnt_r + 32'h1);
      if (per_cnt_r == 32'(PERIOD_CYCLES - 1)) begin
         per_cnt_nxt = 32'h0;
         meas_stb = 1'b1;
      end
      up_cnt_nxt = up_cnt_r;
      if (up_cnt_r < 32'(FIRST_CYCLES)) begin
         up_cnt_nxt = 32'(up_cnt_r + 32'h1);
      end
      meas_n_nxt = meas_n_r;
      if (meas_stb && meas_n_r != 4'hF) begin
         meas_n_nxt = 4'(meas_n_r + 4'h1);
      end
      last_sample_nxt = meas_stb ? sensor_sample : last_sample_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Data-ready sequencer; output is low from reset on
   always_comb begin
      st_nxt = st_r;
      pulse_cnt_nxt = 32'h0;
      unique case (st_r)
         RDY_BOOT: begin
            // Filter must have settled over 'setting' samples as well
            if (fi.done && up_cnt_r >= 32'(FIRST_CYCLES)
                && meas_n_r >= filt_set_r) begin
               st_nxt = RDY_HIGH;
            end
         end
         RDY_LOW: begin
            if (fi.done) begin
               st_nxt = RDY_HIGH;
            end
         end
         RDY_HIGH: begin
            pulse_cnt_nxt = 32'(pulse_cnt_r + 32'h1);
            if (pulse_cnt_r == 32'(PULSE_CYCLES - 1)) begin
               st_nxt = RDY_LOW;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Host requests, only in the low time after the first pulse
   assign accept = host_req && st_r == RDY_LOW;

   always_comb begin
      zero_nxt = zero_r;
      known_nxt = known_r;
      fresh_nxt = fresh_r;
      filt_set_nxt = filt_set_r;
      rdata_nxt = rdata_r;
      ack_nxt = accept;
      ign_nxt = host_req && !accept;
      if (accept) begin
         unique case (host_cmd)
            GSMC_RD_FILT: rdata_nxt = fi.filt_out;
            GSMC_RD_RAW: rdata_nxt = fi.raw_out;
            GSMC_WR_KNOWN: known_nxt = host_wdata;
            GSMC_WR_FRESH: begin
               // Out-of-range reference is clipped to full scale
               fresh_nxt = (host_wdata > FULL_SCALE) ? FULL_SCALE
                                                    : host_wdata;
            end
            GSMC_WR_FILT: filt_set_nxt = host_wdata[3:0];
            // Each zero overwrites the previous one outright
            GSMC_ZERO_KNOWN: zero_nxt = 16'(last_sample_r - known_r);
            GSMC_ZERO_N2: zero_nxt = 16'(last_sample_r - N2_TARGET);
            GSMC_ZERO_FRESH: zero_nxt = 16'(last_sample_r - fresh_r);
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fixed UART bit clock, running only in UART mode
   always_comb begin
      baud_nxt = 1'b0;
      baud_cnt_nxt = 32'h0;
      if (!i2c_r && sel_cnt_r == SEL_CAPTURE_AT) begin
         baud_cnt_nxt = 32'(baud_cnt_r + 32'h1);
         if (baud_cnt_r == 32'(BAUD_CYCLES - 1)) begin
            baud_cnt_nxt = 32'h0;
            baud_nxt = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sel_cnt_r <= 2'h0;
         i2c_r <= 1'b0;
         per_cnt_r <= 32'h0;
         up_cnt_r <= 32'h0;
         meas_n_r <= 4'h0;
         last_sample_r <= 16'h0000;
         st_r <= RDY_BOOT;
         pulse_cnt_r <= 32'h0;
         zero_r <= 16'h0000;
         known_r <= KNOWN_REF_RST;
         fresh_r <= FRESH_REF_RST;
         filt_set_r <= FILT_RST;
         rdata_r <= 16'h0000;
         ack_r <= 1'b0;
         ign_r <= 1'b0;
         baud_cnt_r <= 32'h0;
         baud_r <= 1'b0;
      end else begin
         sel_cnt_r <= sel_cnt_nxt;
         i2c_r <= i2c_nxt;
         per_cnt_r <= per_cnt_nxt;
         up_cnt_r <= up_cnt_nxt;
         meas_n_r <= meas_n_nxt;
         last_sample_r <= last_sample_nxt;
         st_r <= st_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         zero_r <= zero_nxt;
         known_r <= known_nxt;
         fresh_r <= fresh_nxt;
         filt_set_r <= filt_set_nxt;
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
         ign_r <= ign_nxt;
         baud_cnt_r <= baud_cnt_nxt;
         baud_r <= baud_nxt;
      end
   end

   // Filter feed and outputs
   assign fi.sample_stb = meas_stb;
   assign fi.sample = sensor_sample;
   assign fi.zero_pt = zero_r;
   assign fi.setting = filt_set_r;
   assign data_ready = (st_r == RDY_HIGH);
   assign i2c_mode = i2c_r;
   assign host_ack = ack_r;
   assign host_ignored = ign_r;
   assign host_rdata = rdata_r;
   assign baud_tick = baud_r;
   assign zero_point = zero_r;
   assign filter_setting = filt_set_r;
endmodule : gsmc_top

//--- tb/gsmc_asserts.sv
// Checker of data-ready pacing and host request gating
module gsmc_asserts #(
   parameter int FIRST_CYCLES = 50,
   parameter int PERIOD_CYCLES = 200,
   parameter int PULSE_CYCLES = 8
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic host_req,
   input wire logic data_ready,
   input wire logic i2c_mode,
   input wire logic host_ack,
   input wire logic host_ignored,
   input wire logic baud_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   int up_cnt, hi_cnt, per_cnt;
   logic dr_q, booted;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   // Up time, high time, time since last rise; booted once a pulse ends
   always_ff @(posedge clock) begin
      up_cnt <= reset_n ? up_cnt + 1 : 0;
      hi_cnt <= (reset_n && data_ready) ? hi_cnt + 1 : 0;
      per_cnt <= (reset_n && !(data_ready && !dr_q)) ? per_cnt + 1 : 1;
      dr_q <= reset_n && data_ready;
      booted <= reset_n && (booted || (dr_q && !data_ready));
   end
   ////////////////////////////////////////////////////////////////////////
   a_low_after_reset: assert property ($rose(reset_n)
      |-> !data_ready [*3]) else $error("ready not low after reset");
   a_first_late: assert property ($rose(data_ready)
      |-> up_cnt >= FIRST_CYCLES) else $error("ready pulse too early");
   a_pulse_width: assert property ($fell(data_ready)
      |-> hi_cnt == PULSE_CYCLES) else $error("ready width wrong");
   a_period_fixed: assert property ($rose(data_ready) && booted
      |-> per_cnt == PERIOD_CYCLES) else $error("ready period wrong");
   a_busy_refuse: assert property (host_req && data_ready
      |=> host_ignored && !host_ack) else $error("busy request taken");
   a_boot_refuse: assert property (host_req && !booted
      && !$fell(data_ready) |=> host_ignored)
      else $error("boot request taken");
   a_one_answer: assert property (host_req |=> host_ack ^ host_ignored)
      else $error("request not answered once");
   a_mode_hold: assert property (up_cnt > 4 |-> $stable(i2c_mode))
      else $error("mode changed after capture");
   a_i2c_quiet: assert property (i2c_mode && $past(i2c_mode)
      |-> !baud_tick) else $error("baud tick in two-wire mode");
   c_pulse: cover property ($fell(data_ready));
   c_refused: cover property (host_ignored);
   c_accepted: cover property (host_ack);
endmodule : gsmc_asserts

bind gsmc_top gsmc_asserts #(.FIRST_CYCLES(FIRST_CYCLES),
   .PERIOD_CYCLES(PERIOD_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
   .clock, .reset_n, .host_req, .data_ready, .i2c_mode, .host_ack,
   .host_ignored, .baud_tick);

//--- tb/gsmc_host_model.sv
// Host model: requests in the quiet low time of data ready, or at once when told to
module gsmc_host_model #(
   parameter int SETUP_CYC = 60
) (
   input wire logic clock,
   input wire logic data_ready,
   input wire logic host_ack,
   input wire logic host_ignored,
   output logic host_req,
   output gsmc_pkg::gsmc_cmd_t host_cmd,
   output logic [15:0] host_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   import gsmc_pkg::*;
   // Idle at time zero
   initial begin
      host_req = 1'b0;
      host_cmd = GSMC_RD_FILT;
      host_wdata = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // One request; now skips the window wait, for a refusal or a back-to-back request
   task automatic xfer(input gsmc_cmd_t c, input logic [15:0] d,
         input logic now, output logic ack, output logic ign);
      if (!now) begin
         @(negedge data_ready);
         repeat (SETUP_CYC) @(posedge clock);
      end
      @(posedge clock);
      host_req <= 1'b1;
      host_cmd <= c;
      host_wdata <= d;
      @(posedge clock);
      host_req <= 1'b0;
      // Released data changes so stale values cannot pass
      host_wdata <= ~d;
      #1;
      if (!(host_ack || host_ignored)) begin
         @(posedge clock);
         #1;
      end
      ack = host_ack;
      ign = host_ignored;
   endtask : xfer
endmodule : gsmc_host_model

//--- tb/tb_top.sv
// Self-checking bench of the measure cycle sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import gsmc_pkg::*;
   typedef struct {
      gsmc_cmd_t cmd;
      logic [15:0] wd;
      int pick;
      logic [15:0] exp;
   } gsmc_row_t;
   localparam logic [15:0] SAMPLE = 16'h0320;
   logic clock, reset_n, iface_sel_pin, host_req, data_ready, i2c_mode;
   logic host_ack, host_ignored, baud_tick, ack, ign;
   logic [15:0] sensor_sample, host_wdata, host_rdata, zero_point, got;
   logic [3:0] filter_setting;
   gsmc_cmd_t host_cmd;
   int errors = 0, compares = 0, cyc = 0, n, c0;
   // Command, write data, result picked, expected result
   gsmc_row_t rows [11] = '{
      '{GSMC_RD_FILT, 16'h0000, 0, 16'h0320},
      '{GSMC_RD_RAW, 16'h0000, 0, 16'h0320},
      '{GSMC_ZERO_FRESH, 16'h0000, 1, 16'h0190},
      '{GSMC_WR_FRESH, 16'h01F4, 3, 16'h0000},
      // Filter steps toward the corrected value, raw follows at once
      '{GSMC_RD_FILT, 16'h0000, 0, 16'h02EF},
      '{GSMC_RD_RAW, 16'h0000, 0, 16'h0190},
      '{GSMC_ZERO_FRESH, 16'h0000, 1, 16'h012C},
      '{GSMC_WR_KNOWN, 16'h0064, 3, 16'h0000},
      '{GSMC_ZERO_KNOWN, 16'h0000, 1, 16'h02BC},
      '{GSMC_ZERO_N2, 16'h0000, 1, 16'h0320},
      '{GSMC_WR_FILT, 16'h0002, 2, 16'h0002}};
   gsmc_top #(.FIRST_CYCLES(50), .PERIOD_CYCLES(200), .PULSE_CYCLES(8),
      .BAUD_CYCLES(4)) uut (.clock, .reset_n, .iface_sel_pin,
      .sensor_sample, .host_req, .host_cmd, .host_wdata, .data_ready,
      .i2c_mode, .host_ack, .host_ignored, .host_rdata, .baud_tick,
      .zero_point, .filter_setting);
   gsmc_host_model host (.clock, .data_ready, .host_ack, .host_ignored,
      .host_req, .host_cmd, .host_wdata);
   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 10000) begin
         errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check
   task automatic summarize;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // Baud ticks seen over a number of cycles, unknown counts as a tick
   task automatic count_ticks(input int len, output int cnt);
      cnt = 0;
      repeat (len) begin
         @(posedge clock);
         #1;
         if (baud_tick !== 1'b0)
            cnt++;
      end
   endtask : count_ticks
   // Synchronous reset for three cycles with a given select level
   task automatic do_reset(input logic sel);
      @(posedge clock);
      reset_n <= 1'b0;
      iface_sel_pin <= sel;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      c0 = cyc;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      iface_sel_pin = 1'b1;
      sensor_sample = SAMPLE;
      do_reset(1'b1);
      repeat (2) @(posedge clock);
      host.xfer(GSMC_RD_FILT, 16'h0000, 1'b1, ack, ign);
      check({15'h0, ign}, 16'h0001);
      check({15'h0, i2c_mode}, 16'h0000);
      check({15'h0, data_ready}, 16'h0000);
      // One tick every fourth cycle in UART mode
      count_ticks(40, n);
      check(16'(n), 16'h000A);
      n = 0;
      while (data_ready !== 1'b1 && n < 3000) begin
         @(posedge clock);
         #1;
         n++;
      end
      check({15'h0, data_ready}, 16'h0001);
      check({15'h0, cyc - c0 >= FILT_RST * 200}, 16'h0001);
      // A request inside the pulse is dropped
      host.xfer(GSMC_RD_RAW, 16'h0000, 1'b1, ack, ign);
      check({15'h0, ign}, 16'h0001);
      foreach (rows[i]) begin
         host.xfer(rows[i].cmd, rows[i].wd, 1'b0, ack, ign);
         check({15'h0, ack}, 16'h0001);
         got = rows[i].pick == 0 ? host_rdata :
            rows[i].pick == 1 ? zero_point : {12'h0, filter_setting};
         if (rows[i].pick < 3)
            check(got, rows[i].exp);
      end
      host.xfer(GSMC_RD_RAW, 16'h0000, 1'b0, ack, ign);
      check(host_rdata, 16'h0000);
      // Back-to-back reference write and known-gas zero
      host.xfer(GSMC_WR_KNOWN, 16'h0300, 1'b0, ack, ign);
      host.xfer(GSMC_ZERO_KNOWN, 16'h0000, 1'b1, ack, ign);
      check(zero_point, 16'h0020);
      // Mid-run reset into two-wire mode; pin change later is ignored
      do_reset(1'b0);
      repeat (5) @(posedge clock);
      iface_sel_pin <= 1'b1;
      repeat (5) @(posedge clock);
      #1;
      check({15'h0, i2c_mode}, 16'h0001);
      check(zero_point, 16'h0000);
      check({12'h0, filter_setting}, {12'h0, FILT_RST});
      check({15'h0, data_ready}, 16'h0000);
      // Two-wire mode keeps the bit clock silent
      count_ticks(50, n);
      check(16'(n), 16'h0000);
      summarize();
   end
endmodule : tb_top
